// ===== include/isil_consts.svh
// register offsets, field positions and reset values of the status and interrupt block
`ifndef ISIL_CONSTS_SVH
`define ISIL_CONSTS_SVH

`define ISIL_ADDR_W 4
`define ISIL_DATA_W 8

// register offsets
`define ISIL_OFF_CTL 4'h0
`define ISIL_OFF_STAT 4'h1
`define ISIL_OFF_IE 4'h2
`define ISIL_OFF_IFG 4'h3
`define ISIL_OFF_TXBUF 4'h4
`define ISIL_OFF_RXBUF 4'h5

// control register fields
`define ISIL_CTL_SWRST 0
`define ISIL_CTL_I2C 1
`define ISIL_CTL_MST 2
`define ISIL_CTL_SRC_SUB 3
`define ISIL_CTL_RST 8'h03
`define ISIL_CTL_MASK 8'h0F

// status register fields
`define ISIL_STAT_BUSY 4
`define ISIL_STAT_SCL_LOW 6

// flag and enable positions, shared by both registers
`define ISIL_F_AL 0
`define ISIL_F_STT 1
`define ISIL_F_STP 2
`define ISIL_F_NACK 3
`define ISIL_F_TX 4
`define ISIL_F_RX 5
`define ISIL_F_MASK 8'h3F
`define ISIL_DATA_MASK 8'h30
`define ISIL_STATE_MASK 8'h0F
`define ISIL_IE_RST 8'h00
`define ISIL_IFG_RST 8'h00

`endif

// ===== include/isil_pkg.sv
// types shared by the status and interrupt block
package isil_pkg;

   // clock request state, one-hot
   typedef enum logic [1:0] {
      ISIL_CLK_FOLLOW = 2'b01,
      ISIL_CLK_FORCED = 2'b10
   } isil_clk_state_type;

   // events from the protocol sequencer, one-cycle pulses except the levels noted
   typedef struct packed {
      logic start_det;  // start condition seen
      logic stop_det;   // stop condition seen
      logic addr_match; // own address matched with start
      logic nack_rx;    // expected acknowledge missing
      logic arb_lost;   // arbitration lost
      logic rx_loaded;  // byte moved into the receive buffer
      logic tx_taken;   // transmit buffer moved into the shifter
      logic wait_tx;    // level: holding clock low for transmit data
      logic wait_rx;    // level: holding clock low for a receive read
      logic busy;       // level: sequencer not idle
   } isil_evt_type;

   // the two shared request lines
   typedef struct packed {
      logic data;  // transmit and receive vector
      logic state; // state change vector
   } isil_irq_type;

endpackage

// ===== tb/isil_bus_partner.sv
// far side of the two-wire bus: open-drain clock pull-down of other masters and slaves
`timescale 1ns/1ps
module isil_bus_partner (
   input wire logic run_i,      // frame active, clock toggles
   input wire logic stretch_i,  // hold the clock line low
   output logic pull_low_o      // pulls the clock line low
);
   logic phase;

   // link clock of 400 ns period, stands still (released) outside frames
   initial
   begin
      phase = 1'b0;
      forever
      begin
         #200;
         phase = run_i ? ~phase : 1'b0;
      end
   end

   // a stretching slave or a competing master keeps the line low
   assign pull_low_o = stretch_i | phase;
endmodule

// ===== tb/test_i2c_status_interrupt_logic.sv
// testbench of the status, clock request and interrupt flag block
`timescale 1ns/1ps
`include "isil_consts.svh"
module test_i2c_status_interrupt_logic;
   localparam logic [9:0] E_STT = 10'h200;
   localparam logic [9:0] E_STP = 10'h100;
   localparam logic [9:0] E_ADR = 10'h080;
   localparam logic [9:0] E_NACK = 10'h040;
   localparam logic [9:0] E_AL = 10'h020;
   localparam logic [9:0] E_RX = 10'h010;
   localparam logic [9:0] E_TX = 10'h008;
   logic clk_sys_i, rst_b_i, wr, rd, scl_drv, global_irq_enable, crx, ctx, run, stretch;
   logic [3:0] addr;
   logic [7:0] wdata, rxb, rdata, txb, got;
   logic [9:0] pls;
   logic [2:0] lvl;
   logic dtx, drx, sreq, areq, mst, srst;
   isil_pkg::isil_irq_type irq;
   wire isil_pkg::isil_evt_type evt;
   wire logic p_low;
   wire logic scl_line;
   int failures, samples_checked;

   // event pulses merged with the wait and busy levels
   assign evt = isil_pkg::isil_evt_type'(pls | {7'h00, lvl});
   // open-drain clock line with pull-up
   assign scl_line = ~(p_low | scl_drv);

   isil_bus_partner bus_far (.run_i(run), .stretch_i(stretch), .pull_low_o(p_low));

   isil_status_irq uut (
      .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .scl_i(scl_line), .scl_drive_low_i(scl_drv), .evt_i(evt), .rx_byte_i(rxb),
      .global_irq_enable_i(global_irq_enable), .companion_rx_flag_i(crx), .companion_tx_flag_i(ctx), .irq_o(irq),
      .dma_tx_trig_o(dtx), .dma_rx_trig_o(drx), .submain_clk_req_o(sreq), .aux_clk_req_o(areq),
      .master_select_o(mst), .soft_reset_hold_o(srst), .tx_buffer_o(txb));

   // 20 MHz system clock
   initial
   begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   task automatic tick();
      @(posedge clk_sys_i);
      #1;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e)
      begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic bchk(input logic g, input logic e);
      chk({7'h00, g}, {7'h00, e});
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys_i);
      wr <= 1'b0;
      #1;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rchk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_sys_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys_i);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask

   task automatic pulse(input logic [9:0] p);
      @(posedge clk_sys_i);
      pls <= p;
      @(posedge clk_sys_i);
      pls <= 10'h000;
      #1;
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // main sequence
   initial
   begin
      failures = 0;
      samples_checked = 0;
      rst_b_i = 1'b0;
      {wr, rd, scl_drv, global_irq_enable, crx, ctx, run, stretch} = 8'h00;
      addr = 4'h0;
      wdata = 8'h00;
      rxb = 8'h00;
      pls = 10'h000;
      lvl = 3'b000;
      repeat (3) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      tick();
      tick();
      bchk(srst, 1'b1);
      rchk(`ISIL_OFF_CTL, 8'h03);
      rchk(`ISIL_OFF_IFG, 8'h10);
      wr_reg(`ISIL_OFF_IE, 8'h3F);
      rchk(`ISIL_OFF_IE, 8'h0F);
      // leave soft reset, slave, submain source
      wr_reg(`ISIL_OFF_CTL, 8'h0A);
      wr_reg(`ISIL_OFF_IE, 8'h3F);
      @(posedge clk_sys_i) global_irq_enable <= 1'b1;
      tick();
      tick();
      chk({6'h00, irq}, 8'h02);
      bchk(dtx, 1'b1);
      wr_reg(`ISIL_OFF_TXBUF, 8'hC3);
      chk(txb, 8'hC3);
      rchk(`ISIL_OFF_IFG, 8'h00);
      chk({6'h00, irq}, 8'h00);
      bchk(dtx, 1'b0);
      // received byte
      @(posedge clk_sys_i) rxb <= 8'hA5;
      pulse(E_RX);
      bchk(drx, 1'b1);
      chk({6'h00, irq}, 8'h02);
      @(posedge clk_sys_i) global_irq_enable <= 1'b0;
      tick();
      tick();
      chk({6'h00, irq}, 8'h00);
      @(posedge clk_sys_i) global_irq_enable <= 1'b1;
      rchk(`ISIL_OFF_RXBUF, 8'hA5);
      rchk(`ISIL_OFF_IFG, 8'h00);
      tick();
      chk(rdata, 8'h00);
      // companion unit on the shared lines
      @(posedge clk_sys_i) ctx <= 1'b1;
      tick();
      tick();
      chk({6'h00, irq}, 8'h02);
      @(posedge clk_sys_i) {ctx, crx} <= 2'b01;
      tick();
      tick();
      chk({6'h00, irq}, 8'h01);
      @(posedge clk_sys_i) crx <= 1'b0;
      // slave state changes
      pulse(E_STT | E_ADR);
      rchk(`ISIL_OFF_IFG, 8'h02);
      chk({6'h00, irq}, 8'h01);
      pulse(E_STP);
      rchk(`ISIL_OFF_IFG, 8'h04);
      pulse(E_STT);
      rchk(`ISIL_OFF_IFG, 8'h00);
      pulse(E_TX);
      rchk(`ISIL_OFF_IFG, 8'h10);
      pulse(E_NACK);
      rchk(`ISIL_OFF_IFG, 8'h08);
      pulse(E_STT);
      rchk(`ISIL_OFF_IFG, 8'h00);
      wr_reg(`ISIL_OFF_IE, 8'h37);
      pulse(E_NACK);
      chk({6'h00, irq}, 8'h00);
      wr_reg(`ISIL_OFF_IFG, 8'h08);
      rchk(`ISIL_OFF_IFG, 8'h00);
      wr_reg(`ISIL_OFF_IE, 8'h3F);
      // master: start flag refused, then arbitration lost
      wr_reg(`ISIL_OFF_CTL, 8'h0E);
      bchk(mst, 1'b1);
      pulse(E_STT | E_ADR);
      rchk(`ISIL_OFF_IFG, 8'h00);
      pulse(E_AL);
      bchk(mst, 1'b0);
      rchk(`ISIL_OFF_IFG, 8'h01);
      rchk(`ISIL_OFF_CTL, 8'h0A);
      wr_reg(`ISIL_OFF_IFG, 8'h01);
      // submain clock request while busy
      @(posedge clk_sys_i) lvl <= 3'b001;
      tick();
      tick();
      bchk(sreq, 1'b1);
      bchk(areq, 1'b0);
      rchk(`ISIL_OFF_STAT, 8'h10);
      @(posedge clk_sys_i) lvl <= 3'b000;
      tick();
      tick();
      bchk(sreq, 1'b0);
      // clock line stretched by the far side while master
      wr_reg(`ISIL_OFF_CTL, 8'h0E);
      @(posedge clk_sys_i) stretch <= 1'b1;
      repeat (6) tick();
      rchk(`ISIL_OFF_STAT, 8'h40);
      @(posedge clk_sys_i) scl_drv <= 1'b1;
      repeat (6) tick();
      rchk(`ISIL_OFF_STAT, 8'h00);
      @(posedge clk_sys_i) stretch <= 1'b0;
      lvl <= 3'b100;
      repeat (6) tick();
      rchk(`ISIL_OFF_STAT, 8'h40);
      @(posedge clk_sys_i) lvl <= 3'b010;
      repeat (6) tick();
      rchk(`ISIL_OFF_STAT, 8'h40);
      @(posedge clk_sys_i) {lvl, scl_drv} <= 4'h0;
      repeat (6) tick();
      rchk(`ISIL_OFF_STAT, 8'h00);
      // a frame of link clock toggling, status is set while the far side pulls the line low
      @(posedge clk_sys_i) run <= 1'b1;
      repeat (64) tick();
      @(posedge clk_sys_i) run <= 1'b0;
      repeat (16) tick();
      bchk(areq, 1'b0);
      rchk(`ISIL_OFF_STAT, 8'h00);
      // soft reset again with a byte pending
      pulse(E_RX);
      rchk(`ISIL_OFF_IFG, 8'h20);
      wr_reg(`ISIL_OFF_CTL, 8'h03);
      rchk(`ISIL_OFF_IFG, 8'h10);
      rchk(`ISIL_OFF_IE, 8'h0F);
      // unmapped place
      wr_reg(4'hF, 8'hFF);
      rchk(4'hF, 8'h00);
      rchk(`ISIL_OFF_IE, 8'h0F);
      test_done();
   end
endmodule

// ===== verilog/isil_status_irq.sv
// status, clock activation and interrupt flag logic of the two-wire bus controller
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`include "isil_consts.svh"

// Behaviour
// - clock low seen after release reads status, master mode only
// - own clock hold reads status too
// - brief status pulse at rising clock edge, master mode only
// - request submain clock while busy, overriding
// - hold request until idle, then follow
// - never request the auxiliary clock
// - forced clock is chip wide
// - slave mode works on bus clock; wakes
// - two requests: data flags, state flags
// - request needs flag, enable and global enable
// - transmit and receive flags drive DMA
// - tx flag set when ready, cleared write/nack
// - soft reset holds tx flag in I2C mode, clears enable
// - rx flag set on load, cleared read
// - soft reset clears rx flag and enable
// - arbitration loss flags, drops master select
// - nack flag set on nack, start clears
// - start flag on start with address match, slave mode only
// - stop flag on stop in slave mode, start clears
// - state flags share line with companion rx
// - data flags share line with companion tx
module isil_status_irq (
   input wire logic clk_sys_i,                          // system clock, 20 MHz
   input wire logic rst_b_i,                            // asynchronous reset, active low
   input wire logic [`ISIL_ADDR_W-1:0] addr_i,          // register address
   input wire logic [`ISIL_DATA_W-1:0] wdata_i,         // register write data
   input wire logic wr_i,                               // write strobe
   input wire logic rd_i,                               // read strobe
   output logic [`ISIL_DATA_W-1:0] rdata_o,             // read data, cycle after rd_i
   input wire logic scl_i,                              // bus clock line level
   input wire logic scl_drive_low_i,                    // sequencer drives the clock line low
   input wire isil_pkg::isil_evt_type evt_i,            // sequencer events
   input wire logic [`ISIL_DATA_W-1:0] rx_byte_i,       // received byte, valid with rx_loaded
   input wire logic global_irq_enable_i,                // processor global enable
   input wire logic companion_rx_flag_i,                // companion unit enabled receive request
   input wire logic companion_tx_flag_i,                // companion unit enabled transmit request
   output isil_pkg::isil_irq_type irq_o,                // shared request lines
   output logic dma_tx_trig_o,                          // transmit DMA trigger
   output logic dma_rx_trig_o,                          // receive DMA trigger
   output logic submain_clk_req_o,                      // force submain clock on
   output logic aux_clk_req_o,                          // auxiliary clock request, always low
   output logic master_select_o,                        // master mode selected
   output logic soft_reset_hold_o,                      // sequencer held in reset
   output logic [`ISIL_DATA_W-1:0] tx_buffer_o          // byte to transmit
);

   logic [`ISIL_DATA_W-1:0] ctl_ff;
   logic [`ISIL_DATA_W-1:0] ie_ff;
   logic [`ISIL_DATA_W-1:0] ifg_ff;
   logic [`ISIL_DATA_W-1:0] nxt_ctl;
   logic [`ISIL_DATA_W-1:0] nxt_ie;
   logic [`ISIL_DATA_W-1:0] nxt_ifg;
   logic [`ISIL_DATA_W-1:0] tx_buffer_ff;
   logic [`ISIL_DATA_W-1:0] rx_buffer_ff;
   logic [`ISIL_DATA_W-1:0] rdata_ff;
   logic [`ISIL_DATA_W-1:0] nxt_rdata;
   logic scl_meta_ff;
   logic scl_sync_ff;
   logic scl_low_ff;
   logic nxt_scl_low;
   isil_pkg::isil_clk_state_type clk_state_ff;
   isil_pkg::isil_clk_state_type nxt_clk_state;
   logic clk_req_ff;
   logic aux_req_ff;
   isil_pkg::isil_irq_type irq_ff;
   isil_pkg::isil_irq_type nxt_irq;
   logic dma_tx_ff;
   logic dma_rx_ff;
   logic swrst;
   logic i2c_mode;
   logic mst;
   logic wr_ctl;
   logic wr_ie;
   logic wr_ifg;
   logic wr_txbuf;
   logic rd_rxbuf;

   // address decode shared by the strobes
   function automatic logic reg_hit(input logic [`ISIL_ADDR_W-1:0] a, input logic [`ISIL_ADDR_W-1:0] off);
      reg_hit = (a == off);
   endfunction

   // true when any flag in the group is set and enabled
   function automatic logic group_req(input logic [`ISIL_DATA_W-1:0] f, input logic [`ISIL_DATA_W-1:0] e,
                                      input logic [`ISIL_DATA_W-1:0] m);
      group_req = |(f & e & m);
   endfunction

   // strobe decode and control fields
   assign wr_ctl = wr_i & reg_hit(addr_i, `ISIL_OFF_CTL);
   assign wr_ie = wr_i & reg_hit(addr_i, `ISIL_OFF_IE);
   assign wr_ifg = wr_i & reg_hit(addr_i, `ISIL_OFF_IFG);
   assign wr_txbuf = wr_i & reg_hit(addr_i, `ISIL_OFF_TXBUF);
   assign rd_rxbuf = rd_i & reg_hit(addr_i, `ISIL_OFF_RXBUF);
   assign swrst = ctl_ff[`ISIL_CTL_SWRST];
   assign i2c_mode = ctl_ff[`ISIL_CTL_I2C];
   assign mst = ctl_ff[`ISIL_CTL_MST];

   // control register; arbitration loss takes the master bit away
   always_comb
   begin
      nxt_ctl = ctl_ff;
      if (wr_ctl)
      begin
         nxt_ctl = wdata_i & `ISIL_CTL_MASK;
      end
      if (evt_i.arb_lost)
      begin
         nxt_ctl[`ISIL_CTL_MST] = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         ctl_ff <= `ISIL_CTL_RST;
      else
         ctl_ff <= nxt_ctl;
   end

   // enable register; soft reset clears both data enables
   always_comb
   begin
      nxt_ie = ie_ff;
      if (wr_ie)
      begin
         nxt_ie = wdata_i & `ISIL_F_MASK;
      end
      if (swrst)
      begin
         nxt_ie[`ISIL_F_TX] = 1'b0;
         nxt_ie[`ISIL_F_RX] = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         ie_ff <= `ISIL_IE_RST;
      else
         ie_ff <= nxt_ie;
   end

   // flags: clears first, then sets, then soft reset clears rx; an event in any other clearing cycle survives
   always_comb
   begin
      nxt_ifg = ifg_ff;
      if (wr_ifg)
      begin
         nxt_ifg = ifg_ff & ~wdata_i; // write one to clear
      end
      if (evt_i.start_det)
      begin
         nxt_ifg[`ISIL_F_NACK] = 1'b0;
         nxt_ifg[`ISIL_F_STP] = 1'b0;
      end
      if (evt_i.stop_det)
      begin
         nxt_ifg[`ISIL_F_STT] = 1'b0;
      end
      if (wr_txbuf | evt_i.nack_rx)
      begin
         nxt_ifg[`ISIL_F_TX] = 1'b0;
      end
      if (rd_rxbuf)
      begin
         nxt_ifg[`ISIL_F_RX] = 1'b0;
      end
      if (evt_i.arb_lost)
      begin
         nxt_ifg[`ISIL_F_AL] = 1'b1;
      end
      if (evt_i.nack_rx)
      begin
         nxt_ifg[`ISIL_F_NACK] = 1'b1;
      end
      if (evt_i.start_det & evt_i.addr_match & ~mst)
      begin
         nxt_ifg[`ISIL_F_STT] = 1'b1;
      end
      if (evt_i.stop_det & ~mst)
      begin
         nxt_ifg[`ISIL_F_STP] = 1'b1;
      end
      if (evt_i.tx_taken | (swrst & i2c_mode))
      begin
         nxt_ifg[`ISIL_F_TX] = 1'b1;
      end
      if (evt_i.rx_loaded)
      begin
         nxt_ifg[`ISIL_F_RX] = 1'b1;
      end
      if (swrst)
      begin
         nxt_ifg[`ISIL_F_RX] = 1'b0; // reset wins here
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         ifg_ff <= `ISIL_IFG_RST;
      else
         ifg_ff <= nxt_ifg;
   end

   // data buffers
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         tx_buffer_ff <= '0;
         rx_buffer_ff <= '0;
      end
      else
      begin
         if (wr_txbuf)
            tx_buffer_ff <= wdata_i;
         if (evt_i.rx_loaded)
            rx_buffer_ff <= rx_byte_i;
      end
   end

   // bus clock line synchroniser
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         scl_meta_ff <= 1'b1;
         scl_sync_ff <= 1'b1;
      end
      else
      begin
         scl_meta_ff <= scl_i;
         scl_sync_ff <= scl_meta_ff;
      end
   end

   // clock held low: in master mode someone else holds it after release, or we hold it waiting
   // in master mode the synchroniser lag makes this pulse briefly on each rising edge we release
   assign nxt_scl_low = (mst & ~scl_drive_low_i & ~scl_sync_ff)
                        | evt_i.wait_tx | evt_i.wait_rx;

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         scl_low_ff <= 1'b0;
      else
         scl_low_ff <= nxt_scl_low;
   end

   // submain clock request; the request goes to the chip clock system, not a gate
   always_comb
   begin
      nxt_clk_state = clk_state_ff;
      unique case (clk_state_ff)
         isil_pkg::ISIL_CLK_FOLLOW:
         begin
            if (ctl_ff[`ISIL_CTL_SRC_SUB] & evt_i.busy)
               nxt_clk_state = isil_pkg::ISIL_CLK_FORCED;
         end
         isil_pkg::ISIL_CLK_FORCED:
         begin
            if (~evt_i.busy)
               nxt_clk_state = isil_pkg::ISIL_CLK_FOLLOW;
         end
         default:
         begin
            nxt_clk_state = isil_pkg::ISIL_CLK_FOLLOW;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         clk_state_ff <= isil_pkg::ISIL_CLK_FOLLOW;
         clk_req_ff <= 1'b0;
         aux_req_ff <= 1'b0;
      end
      else
      begin
         clk_state_ff <= nxt_clk_state;
         clk_req_ff <= (nxt_clk_state == isil_pkg::ISIL_CLK_FORCED);
         aux_req_ff <= 1'b0;
      end
   end

   // request lines, level held while any enabled flag stays set
   always_comb
   begin
      nxt_irq.data = global_irq_enable_i &
                     (group_req(nxt_ifg, nxt_ie, `ISIL_DATA_MASK) | companion_tx_flag_i);
      nxt_irq.state = global_irq_enable_i &
                      (group_req(nxt_ifg, nxt_ie, `ISIL_STATE_MASK) | companion_rx_flag_i);
   end

   // request and trigger flops; they run without the internal clocks gated only by the sequencer
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         irq_ff <= '0;
         dma_tx_ff <= 1'b0;
         dma_rx_ff <= 1'b0;
      end
      else
      begin
         irq_ff <= nxt_irq;
         dma_tx_ff <= nxt_ifg[`ISIL_F_TX];
         dma_rx_ff <= nxt_ifg[`ISIL_F_RX];
      end
   end

   // read mux, answer in the cycle after the strobe
   always_comb
   begin
      nxt_rdata = '0;
      if (rd_i)
      begin
         unique case (addr_i)
            `ISIL_OFF_CTL: nxt_rdata = ctl_ff;
            `ISIL_OFF_STAT:
            begin
               nxt_rdata[`ISIL_STAT_SCL_LOW] = scl_low_ff;
               nxt_rdata[`ISIL_STAT_BUSY] = evt_i.busy;
            end
            `ISIL_OFF_IE: nxt_rdata = ie_ff;
            `ISIL_OFF_IFG: nxt_rdata = ifg_ff;
            `ISIL_OFF_TXBUF: nxt_rdata = tx_buffer_ff;
            `ISIL_OFF_RXBUF: nxt_rdata = rx_buffer_ff;
            default: nxt_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         rdata_ff <= '0;
      else
         rdata_ff <= nxt_rdata;
   end

   // outputs
   assign rdata_o = rdata_ff;
   assign irq_o = irq_ff;
   assign dma_tx_trig_o = dma_tx_ff;
   assign dma_rx_trig_o = dma_rx_ff;
   assign submain_clk_req_o = clk_req_ff;
   assign aux_clk_req_o = aux_req_ff;
   assign master_select_o = ctl_ff[`ISIL_CTL_MST];
   assign soft_reset_hold_o = ctl_ff[`ISIL_CTL_SWRST];
   assign tx_buffer_o = tx_buffer_ff;

   // checks
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence released_low_s;
      mst & ~scl_drive_low_i & ~scl_sync_ff;
   endsequence

   sequence rx_load_then_read_s;
      evt_i.rx_loaded ##[1:8] (rd_rxbuf & ~evt_i.rx_loaded & ~swrst);
   endsequence

   sequence busy_then_idle_s;
      (ctl_ff[`ISIL_CTL_SRC_SUB] & evt_i.busy) ##1 (~evt_i.busy)[*2];
   endsequence

   scl_released_a: assert property (released_low_s |=> scl_low_ff)
      else $error("clock low after release not reported");
   scl_wait_a: assert property ((evt_i.wait_tx | evt_i.wait_rx) |=> scl_low_ff)
      else $error("own clock hold not reported");
   scl_free_a: assert property ((~mst & ~evt_i.wait_tx & ~evt_i.wait_rx) |=> ~scl_low_ff)
      else $error("clock low status set without cause");
   clk_force_a: assert property ((ctl_ff[`ISIL_CTL_SRC_SUB] & evt_i.busy) |=> submain_clk_req_o)
      else $error("submain clock not requested while busy");
   clk_release_a: assert property (busy_then_idle_s |=> ~submain_clk_req_o)
      else $error("submain request held after idle");
   aux_never_a: assert property (~aux_clk_req_o)
      else $error("auxiliary clock requested");
   irq_gie_a: assert property (~global_irq_enable_i |=> ~irq_o.data & ~irq_o.state)
      else $error("request raised without global enable");
   irq_level_a: assert property ((global_irq_enable_i & ifg_ff[`ISIL_F_RX] & ie_ff[`ISIL_F_RX] & ~rd_rxbuf
                                  & ~swrst & ~wr_ifg & ~wr_ie) |=> irq_o.data)
      else $error("data request dropped while flag enabled");
   dma_follow_a: assert property (dma_tx_trig_o == ifg_ff[`ISIL_F_TX] && dma_rx_trig_o == ifg_ff[`ISIL_F_RX])
      else $error("DMA trigger differs from flag");
   tx_write_a: assert property ((wr_txbuf & ~evt_i.tx_taken & ~(swrst & i2c_mode)) |=> ~ifg_ff[`ISIL_F_TX])
      else $error("transmit flag not cleared by buffer write");
   tx_swrst_a: assert property ((swrst & i2c_mode) |=> ifg_ff[`ISIL_F_TX] & ~ie_ff[`ISIL_F_TX])
      else $error("soft reset did not hold transmit flag");
   rx_read_a: assert property (rx_load_then_read_s |=> ~ifg_ff[`ISIL_F_RX])
      else $error("receive flag survived buffer read");
   rx_swrst_a: assert property (swrst |=> ~ifg_ff[`ISIL_F_RX] & ~ie_ff[`ISIL_F_RX])
      else $error("soft reset left receive flag or enable");
   arb_lost_a: assert property (evt_i.arb_lost |=> ifg_ff[`ISIL_F_AL] & ~master_select_o)
      else $error("arbitration loss not handled");
   // a transmit-flag set in the same cycle wins over the nack clear
   nack_flag_a: assert property (evt_i.nack_rx |=> ifg_ff[`ISIL_F_NACK]
                                 & (~ifg_ff[`ISIL_F_TX] | $past(evt_i.tx_taken | (swrst & i2c_mode))))
      else $error("nack flag not set");
   start_flag_a: assert property ((evt_i.start_det & evt_i.addr_match & ~mst) |=> ifg_ff[`ISIL_F_STT])
      else $error("start flag not set");
   stop_flag_a: assert property ((evt_i.start_det & ~evt_i.stop_det & ~evt_i.nack_rx) |=>
                                 ~ifg_ff[`ISIL_F_STP] & ~ifg_ff[`ISIL_F_NACK])
      else $error("start did not clear stop or nack flag");
   companion_a: assert property ((global_irq_enable_i & companion_rx_flag_i) |=> irq_o.state)
      else $error("companion receive request lost");

endmodule
